// >>> logic/svd_pkg.sv
package svd_pkg;

  // ****************************************************************
  // bus map
  // ****************************************************************
  localparam logic [13:0] level_index        = 14'h0fc6;
  localparam logic [13:0] mode_index         = 14'h0fc7;
  localparam logic [13:0] irq_status_index   = 14'h0fc8;
  localparam logic [13:0] irq_clear_index    = 14'h0fc9;
  localparam logic [13:0] irq_enable_index   = 14'h0fca;
  localparam int          addr_width         = 16;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int          ch2_sticky_bit     = 7;
  localparam int          ch2_live_bit       = 6;
  localparam int          ch2_code_lsb       = 4;
  localparam int          ch1_sticky_bit     = 3;
  localparam int          ch1_live_bit       = 2;
  localparam int          ch1_code_lsb       = 0;
  localparam int          ch1_en_bit         = 0;
  localparam int          ch1_mode_bit       = 1;
  localparam int          ch2_en_bit         = 2;
  localparam int          ch2_mode_bit       = 3;
  localparam logic [7:0]  level_reset        = 8'h20;
  localparam logic [7:0]  mode_reset         = 8'h00;
  localparam logic [7:0]  mode_write_mask    = 8'h3f;
  localparam logic        action_irq         = 1'b0;

  // ****************************************************************
  // level codes, names only for readability of the threshold port
  // ****************************************************************
  localparam logic [1:0]  ch1_lvl_4v50       = 2'h0;
  localparam logic [1:0]  ch1_lvl_4v20       = 2'h1;
  localparam logic [1:0]  ch1_lvl_3v70       = 2'h2;
  localparam logic [1:0]  ch1_lvl_3v15       = 2'h3;
  localparam logic [1:0]  ch2_lvl_2v35       = 2'h0;
  localparam logic [1:0]  ch2_lvl_3v15       = 2'h1;
  localparam logic [1:0]  ch2_lvl_2v85       = 2'h2;
  localparam logic [1:0]  ch2_lvl_2v65       = 2'h3;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [15:0] address;
    logic [31:0] writedata;
  } bus_req_type;

  typedef struct packed {
    logic       sticky;
    logic       live;
    logic       edge_evt;
    logic       reset_req;
  } chan_out_type;

endpackage

// >>> logic/comp_sync.sv
`timescale 1ns/1ps
module comp_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  // ****************************************************************
  // two-stage synchroniser; first stage read only by second
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> logic/svd_channel.sv
`timescale 1ns/1ps
module svd_channel (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  below_sync,
  input  wire logic                  enable,
  input  wire logic                  action,
  input  wire logic                  clear_sticky,
  output svd_pkg::chan_out_type      status
);
  typedef struct packed {
    logic below_q;
    logic sticky;
  } chan_state_type;

  chan_state_type state;
  chan_state_type next_state;
  logic           below;

  always_comb begin
    next_state = state;
    below      = enable & below_sync;
    // enable low keeps the flag; only a written 0 clears it
    if (clear_sticky) begin
      next_state.sticky = 1'b0;
    end
    if (below) begin
      next_state.sticky = 1'b1;
    end
    next_state.below_q = below;
    status.sticky    = state.sticky;
    status.live      = below;
    // either edge: no hysteresis means rising crossings also count
    // gated by enable: switching off must not look like a rise
    status.edge_evt  = (below ^ state.below_q)
                       & (action == svd_pkg::action_irq)
                       & enable;
    status.reset_req = below & (action != svd_pkg::action_irq);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// >>> logic/supply_voltage_detect_ctrl.sv
// Notes on behaviour
// - two channels, each with own threshold
// - per channel choose reset or interrupt
// - interrupt on crossing either direction
// - channel 2 sticky set, cleared by 0
// - channel 2 live flag, read only
// - channel 2 code picks four levels
// - channel 1 sticky latches on detection
// - channel 1 live flag, read only
// - channel 1 code picks four levels
// - only power-on or external reset clears (code: a written 0 also clears channel 1 sticky)
// - set beats clear on same cycle
// - writing 1 never sets sticky flags
// - mode bit 0 interrupt, 1 reset
// - enable bit gates whole channel
// - reset request held while below threshold
// - disabling keeps latched sticky flag
`timescale 1ns/1ps
module supply_voltage_detect_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        chan1_below_async,
  input  wire logic        chan2_below_async,
  output logic [1:0]       chan1_threshold_code,
  output logic [1:0]       chan2_threshold_code,
  output logic             supply_monitor_irq,
  output logic             supply_monitor_reset_req
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  code1;
    logic [1:0]  code2;
    logic [7:0]  mode;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic        rst_req;
  } ctrl_state_type;

  ctrl_state_type           state;
  ctrl_state_type           next_state;
  logic                     below1;
  logic                     below2;
  logic                     wr_level;
  logic                     clr1;
  logic                     clr2;
  logic [7:0]               level_view;
  logic [13:0]              index;
  logic                     access;
  svd_pkg::chan_out_type    ch1;
  svd_pkg::chan_out_type    ch2;

  // ****************************************************************
  // comparator inputs
  // ****************************************************************
  comp_sync sync1 (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (chan1_below_async),
    .sync_out (below1)
  );

  comp_sync sync2 (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (chan2_below_async),
    .sync_out (below2)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  function automatic logic hit(input logic [13:0] idx,
                               input logic [13:0] want);
    hit = (idx == want);
  endfunction

  assign index    = avs_address[15:2];
  assign access   = (avs_read | avs_write) & ~state.ack;
  assign wr_level = access & avs_write & avs_byteenable[0]
                    & hit(index, svd_pkg::level_index);
  // only a written 0 clears; a 1 is ignored
  assign clr1     = wr_level
                    & ~avs_writedata[svd_pkg::ch1_sticky_bit];
  assign clr2     = wr_level
                    & ~avs_writedata[svd_pkg::ch2_sticky_bit];

  // ****************************************************************
  // channels
  // ****************************************************************
  svd_channel chan1 (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .below_sync   (below1),
    .enable       (state.mode[svd_pkg::ch1_en_bit]),
    .action       (state.mode[svd_pkg::ch1_mode_bit]),
    .clear_sticky (clr1),
    .status       (ch1)
  );

  svd_channel chan2 (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .below_sync   (below2),
    .enable       (state.mode[svd_pkg::ch2_en_bit]),
    .action       (state.mode[svd_pkg::ch2_mode_bit]),
    .clear_sticky (clr2),
    .status       (ch2)
  );

  always_comb begin
    level_view = '0;
    level_view[svd_pkg::ch2_sticky_bit] = ch2.sticky;
    level_view[svd_pkg::ch2_live_bit]   = ch2.live;
    level_view[svd_pkg::ch2_code_lsb +: 2] = state.code2;
    level_view[svd_pkg::ch1_sticky_bit] = ch1.sticky;
    level_view[svd_pkg::ch1_live_bit]   = ch1.live;
    level_view[svd_pkg::ch1_code_lsb +: 2] = state.code1;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state         = state;
    next_state.ack     = access;
    next_state.rdata   = '0;
    if (access & avs_write & avs_byteenable[0]) begin
      if (hit(index, svd_pkg::level_index)) begin
        next_state.code1 =
          avs_writedata[svd_pkg::ch1_code_lsb +: 2];
        next_state.code2 =
          avs_writedata[svd_pkg::ch2_code_lsb +: 2];
      end
      if (hit(index, svd_pkg::mode_index)) begin
        next_state.mode = avs_writedata[7:0] & svd_pkg::mode_write_mask;
      end
      if (hit(index, svd_pkg::irq_enable_index)) begin
        next_state.irq_enable = avs_writedata[1:0];
      end
      if (hit(index, svd_pkg::irq_clear_index)) begin
        next_state.irq_status = state.irq_status & ~avs_writedata[1:0];
      end
    end
    // events after the clear so that a coincident event survives
    if (ch1.edge_evt) begin
      next_state.irq_status[0] = 1'b1;
    end
    if (ch2.edge_evt) begin
      next_state.irq_status[1] = 1'b1;
    end
    if (access & avs_read) begin
      case (index)
        svd_pkg::level_index:      next_state.rdata = {24'h0, level_view};
        svd_pkg::mode_index:       next_state.rdata = {24'h0, state.mode};
        svd_pkg::irq_status_index:
          next_state.rdata = {30'h0, state.irq_status};
        svd_pkg::irq_enable_index:
          next_state.rdata = {30'h0, state.irq_enable};
        default:                   next_state.rdata = '0;
      endcase
    end
    next_state.irq     = |(next_state.irq_status & state.irq_enable);
    next_state.rst_req = ch1.reset_req | ch2.reset_req;
  end

  // ****************************************************************
  // registers: only sys_rst (power-on / external) clears them
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= '0;
      state.code2 <= svd_pkg::level_reset[svd_pkg::ch2_code_lsb +: 2];
      state.code1 <= svd_pkg::level_reset[svd_pkg::ch1_code_lsb +: 2];
      state.mode  <= svd_pkg::mode_reset;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata             = state.rdata;
  assign avs_waitrequest          = ~state.ack & (avs_read | avs_write);
  assign chan1_threshold_code     = state.code1;
  assign chan2_threshold_code     = state.code2;
  assign supply_monitor_irq       = state.irq;
  assign supply_monitor_reset_req = state.rst_req;

endmodule

// >>> test/svd_props.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module svd_props (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        chan1_below_async,
  input wire logic        chan2_below_async,
  input wire logic [1:0]  chan1_threshold_code,
  input wire logic [1:0]  chan2_threshold_code,
  input wire logic        supply_monitor_irq,
  input wire logic        supply_monitor_reset_req
);
  logic       wr_done;
  logic       lvl_wr;
  logic [7:0] last_wd;
  assign wr_done = avs_write && !avs_waitrequest;
  assign lvl_wr = wr_done && avs_byteenable[0]
    && avs_address[15:2] == svd_pkg::level_index;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      last_wd <= 8'h00;
    else if (lvl_wr)
      last_wd <= avs_writedata[7:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence req_new; $rose(avs_read) || $rose(avs_write); endsequence
  sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  chk_one_wait: assert property (req_new |-> one_wait)
    else $error("request not answered after one wait");
  chk_idle_nowait: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait raised while idle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address[15:2] > svd_pkg::irq_enable_index |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  chk_code_write: assert property (lvl_wr |-> ##[1:2] (
    chan1_threshold_code == last_wd[1:0]
    && chan2_threshold_code == last_wd[5:4]))
    else $error("threshold code not taken from write");
  chk_code_hold: assert property (
    $changed({chan2_threshold_code, chan1_threshold_code})
    |-> wr_done)
    else $error("threshold code moved without write");
  chk_irq_fall: assert property ($fell(supply_monitor_irq)
    |-> wr_done || $past(wr_done))
    else $error("irq dropped without write");
  chk_rreq_sync: assert property (
    $rose(supply_monitor_reset_req)
    |-> $past(chan1_below_async || chan2_below_async, 2))
    else $error("reset request rose too early");
  chk_rreq_drop: assert property (
    $fell(supply_monitor_reset_req) |-> $past(wr_done)
    || $past(wr_done, 2)
    || $past(!chan1_below_async || !chan2_below_async, 2))
    else $error("reset request dropped while below");
endmodule

// >>> test/comp_model.sv
`timescale 1ns/1ps
// ****************************************************************
// comparator, thresholds in millivolts
// ****************************************************************
module comp_model (
  input  wire logic [12:0] supply_mv,
  input  wire logic [1:0]  code1,
  input  wire logic [1:0]  code2,
  output logic             below1,
  output logic             below2
);
  localparam logic [12:0] lvl1 [4] = '{13'h1194, 13'h1068, 13'h0e74,
                                       13'h0c4e};
  localparam logic [12:0] lvl2 [4] = '{13'h092e, 13'h0c4e, 13'h0b22,
                                       13'h0a5a};
  // strict compare, no hysteresis, so equal counts as above
  assign below1 = supply_mv < lvl1[code1];
  assign below2 = supply_mv < lvl2[code2];
endmodule

// >>> test/test_supply_voltage_detect_ctrl.sv
`timescale 1ns/1ps
// ****************************************************************
// bench
// ****************************************************************
module test_supply_voltage_detect_ctrl;
  logic        ref_clk;
  logic        sys_rst;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        chan1_below_async;
  logic        chan2_below_async;
  logic [1:0]  chan1_threshold_code;
  logic [1:0]  chan2_threshold_code;
  logic        supply_monitor_irq;
  logic        supply_monitor_reset_req;
  logic [12:0] supply_mv;
  int          num_errors;
  int          num_checks;
  supply_voltage_detect_ctrl uut (.*);
  comp_model partner (.supply_mv(supply_mv), .code1(chan1_threshold_code),
    .code2(chan2_threshold_code), .below1(chan1_below_async),
    .below2(chan2_below_async));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [13:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [13:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    cmp("readdata", {24'h0, e}, q);
  endtask
  // supply change, then long enough for sync and flags to land
  task automatic go(input logic [12:0] mv);
    @(posedge ref_clk);
    supply_mv <= mv;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic pins(input logic i, input logic r);
    cmp("irq", {31'h0, i}, {31'h0, supply_monitor_irq});
    cmp("reset_req", {31'h0, r}, {31'h0, supply_monitor_reset_req});
  endtask
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 16'h0000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    supply_mv = 13'h1388;
    num_errors = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(svd_pkg::level_index, 8'h20);
    rd(svd_pkg::mode_index, 8'h00);
    rd(14'h0fcb, 8'h00);
    wr(svd_pkg::level_index, 8'hff);
    rd(svd_pkg::level_index, 8'h33);
    for (int i = 0; i < 4; i++) begin
      wr(svd_pkg::level_index, {2'h0, i[1:0], 2'h0, ~i[1:0]});
      repeat (2) @(posedge ref_clk);
      cmp("codes", {28'h0, i[1:0], ~i[1:0]},
          {28'h0, chan2_threshold_code, chan1_threshold_code});
    end
    wr(svd_pkg::level_index, 8'h20);
    wr(svd_pkg::irq_enable_index, 8'h03);
    wr(svd_pkg::mode_index, 8'h0d);
    go(13'h0fa0);
    pins(1'b1, 1'b0);
    rd(svd_pkg::irq_status_index, 8'h01);
    wr(svd_pkg::irq_enable_index, 8'h00);
    go(13'h0fa0);
    pins(1'b0, 1'b0);
    wr(svd_pkg::irq_clear_index, 8'h03);
    wr(svd_pkg::irq_enable_index, 8'h03);
    go(13'h0fa0);
    pins(1'b0, 1'b0);
    go(13'h1388);
    pins(1'b1, 1'b0);
    rd(svd_pkg::level_index, 8'h28);
    wr(svd_pkg::level_index, 8'h20);
    wr(svd_pkg::irq_clear_index, 8'h03);
    rd(svd_pkg::level_index, 8'h20);
    go(13'h09c4);
    pins(1'b1, 1'b1);
    wr(svd_pkg::level_index, 8'h20);
    rd(svd_pkg::level_index, 8'hec);
    go(13'h09c4);
    pins(1'b1, 1'b1);
    go(13'h0bb8);
    pins(1'b1, 1'b0);
    rd(svd_pkg::level_index, 8'hac);
    wr(svd_pkg::mode_index, 8'h00);
    rd(svd_pkg::level_index, 8'ha8);
    wr(svd_pkg::level_index, 8'h20);
    wr(svd_pkg::irq_clear_index, 8'h03);
    go(13'h07d0);
    rd(svd_pkg::level_index, 8'h20);
    pins(1'b0, 1'b0);
    wr(svd_pkg::mode_index, 8'hc3);
    rd(svd_pkg::mode_index, 8'h03);
    go(13'h07d0);
    pins(1'b0, 1'b1);
    wr(svd_pkg::mode_index, 8'h04);
    go(13'h07d0);
    pins(1'b1, 1'b0);
    rd(svd_pkg::irq_status_index, 8'h02);
    avs_byteenable <= 4'he;
    wr(svd_pkg::level_index, 8'h33);
    avs_byteenable <= 4'hf;
    rd(svd_pkg::level_index, 8'he8);
    close_out();
  end
endmodule
bind supply_voltage_detect_ctrl svd_props chk (.*);
